//--- logic/dmi_pkg.sv
// Package for the data-move instruction executor: opcodes, field layouts,
// widths, reset values and the cycle budget of one instruction.
// Assumes a single core clock and a synchronous, active-low core reset.

package dmi_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DMI_PTR_W = 16;
  localparam int DMI_ACC_W = 8;
  localparam int DMI_BANK_W = 5;
  localparam int DMI_PCL_W = 7;
  localparam int DMI_FILE_W = 7;
  localparam int DMI_OFS_W = 6;
  localparam int DMI_NUM_PTR = 2;

  // ----------------------------------------------------------------------
  // Reset values and fixed addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] DMI_PTR_RST = 16'h0000;
  localparam logic [7:0] DMI_ACC_RST = 8'h00;
  localparam logic [4:0] DMI_BANK_RST = 5'h00;
  localparam logic [6:0] DMI_PCL_RST = 7'h00;
  localparam logic DMI_ZERO_RST = 1'b0;
  // Direct addresses that stand for the indirect data ports 0 and 1
  localparam logic [6:0] DMI_IND_PORT0_ADDR = 7'h00;
  localparam logic [6:0] DMI_IND_PORT1_ADDR = 7'h01;
  localparam logic [15:0] DMI_PTR_STEP = 16'h0001;

  // ----------------------------------------------------------------------
  // Timing: clocks from instruction accept to done pulse
  // ----------------------------------------------------------------------
  localparam int DMI_INSTR_CLOCKS = 3;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DMI_OP_NOP = 3'h0,
    DMI_OP_INDIRECT_LOAD_TO_ACC = 3'h1,
    DMI_OP_LOAD_BANK_LITERAL = 3'h2,
    DMI_OP_LOAD_PC_LATCH_LITERAL = 3'h3,
    DMI_OP_LOAD_ACC_LITERAL = 3'h4,
    DMI_OP_STORE_ACC_TO_FILE = 3'h5
  } dmi_op_type;

  // Pointer update mode: bit 1 selects post, bit 0 selects decrement
  typedef enum logic [1:0] {
    DMI_MODE_PRE_INC = 2'h0,
    DMI_MODE_PRE_DEC = 2'h1,
    DMI_MODE_POST_INC = 2'h2,
    DMI_MODE_POST_DEC = 2'h3
  } dmi_pointer_update_mode_type;

  typedef enum logic [1:0] {
    DMI_ST_IDLE = 2'b00,
    DMI_ST_DECODE = 2'b01,
    DMI_ST_ACCESS = 2'b11,
    DMI_ST_WRITE = 2'b10
  } dmi_state_type;

  // One decoded instruction word
  typedef struct packed {
    dmi_op_type op;
    logic ptr_sel;
    dmi_pointer_update_mode_type mode;
    logic relative;
    logic [5:0] offset;
    logic [7:0] literal;
    logic [6:0] file_addr;
  } dmi_instr_type;

  // Data memory request
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dmi_mem_req_type;

endpackage : dmi_pkg

//--- logic/dmi_pointer.sv
// One 16-bit indirect pointer with software load and instruction update.
// Assumes the executor never asks for an update and a load it cares about
// in the same clock; a non-relative update wins there.

`timescale 1ns/10ps
`default_nettype none

module dmi_pointer
  import dmi_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic load_en_in,
  input wire logic [15:0] load_val_in,
  input wire logic update_en_in,
  input wire logic relative_in,
  input wire logic decrement_in,
  output logic [15:0] ptr_out
);

  typedef struct packed {
    logic [15:0] ptr;
  } dmi_ptr_state_type;

  dmi_ptr_state_type st_r;
  dmi_ptr_state_type st_nxt;

  // ----------------------------------------------------------------------
  // Next pointer value
  // ----------------------------------------------------------------------
  // Plain 16-bit add and subtract wrap at both ends for free
  always_comb
  begin
    st_nxt = st_r;
    if (update_en_in && !relative_in)
    begin
      if (decrement_in)
        st_nxt.ptr = st_r.ptr - DMI_PTR_STEP;
      else
        st_nxt.ptr = st_r.ptr + DMI_PTR_STEP;
    end
    // A relative-form update leaves the pointer alone, so a load still lands
    else if (load_en_in)
      st_nxt.ptr = load_val_in;
  end

  // State register
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      st_r <= '{ptr: DMI_PTR_RST};
    else
      st_r <= st_nxt;
  end

  assign ptr_out = st_r.ptr;

endmodule : dmi_pointer

`default_nettype wire

//--- logic/dmi_exec.sv
// Executor for the data-move instructions of a small 8-bit core: indirect
// load, three literal loads and the store to a file register.
// Assumes a data memory on the same clock that returns read data in the
// same clock as the read strobe, and an instruction source that holds no more
// than one instruction in flight (it waits for ready).
//
// Functional notes
// - Indirect load address from pointer by mode: pre-inc, pre-dec, post-inc, post-dec.
// - Relative form: address is pointer plus signed offset -32 to 31.
// - Afterwards pointer is plus one, minus one, or unchanged for relative.
// - Indirect data port has no storage; accesses go to pointer's address.
// - Pointer is 16 bits and wraps at both ends.
// - Bank literal load writes 5-bit operand into bank select register.
// - PC latch literal load writes 7-bit operand into upper PC latch.
// - Accumulator literal load writes 8-bit operand into working register.
// - Store copies working register to directly addressed file, register unchanged.

`timescale 1ns/10ps
`default_nettype none

module dmi_exec
  import dmi_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire dmi_instr_type instr_in,
  input wire logic instr_valid_in,
  output logic instr_ready_out,
  output logic done_out,
  input wire logic ptr_load_en_in,
  input wire logic ptr_load_sel_in,
  input wire logic [15:0] ptr_load_val_in,
  output dmi_mem_req_type mem_req_out,
  input wire logic [7:0] mem_rdata_in,
  output logic [7:0] acc_out,
  output logic [4:0] bank_select_reg_out,
  output logic [6:0] pc_high_latch_out,
  output logic zero_flag_out,
  output logic [15:0] ptr0_out,
  output logic [15:0] ptr1_out
);

  typedef struct packed {
    dmi_state_type state;
    dmi_instr_type instr;
    dmi_mem_req_type mem;
    logic [7:0] acc;
    logic [4:0] bank;
    logic [6:0] pcl;
    logic zero;
    logic ptr_upd;
  } dmi_exec_state_type;

  dmi_exec_state_type st_r;
  dmi_exec_state_type st_nxt;
  logic [15:0] ptr_val [DMI_NUM_PTR];
  logic [15:0] sel_ptr;
  logic [15:0] offset_ext;
  logic [15:0] ind_addr;
  logic [15:0] store_addr;
  logic is_ind;

  // ----------------------------------------------------------------------
  // Indirect pointers
  // ----------------------------------------------------------------------
  // Update only in the write clock, after the read used the old value
  for (genvar i = 0; i < DMI_NUM_PTR; i++)
  begin : g_ptr
    dmi_pointer u_ptr (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .load_en_in(ptr_load_en_in && (ptr_load_sel_in == 1'(i))),
      .load_val_in(ptr_load_val_in),
      .update_en_in(st_r.ptr_upd && (st_r.instr.ptr_sel == 1'(i))),
      .relative_in(st_r.instr.relative),
      .decrement_in(st_r.instr.mode[0]),
      .ptr_out(ptr_val[i])
    );
  end

  // ----------------------------------------------------------------------
  // Address forming
  // ----------------------------------------------------------------------
  assign is_ind = (st_r.instr.op == DMI_OP_INDIRECT_LOAD_TO_ACC);
  assign sel_ptr = ptr_val[st_r.instr.ptr_sel];
  assign offset_ext = {{10{st_r.instr.offset[5]}}, st_r.instr.offset};

  // Pre modes step before the access, post modes use the pointer as is
  always_comb
  begin
    if (st_r.instr.relative)
      ind_addr = sel_ptr + offset_ext;
    else
    begin
      case (st_r.instr.mode)
        DMI_MODE_PRE_INC: ind_addr = sel_ptr + DMI_PTR_STEP;
        DMI_MODE_PRE_DEC: ind_addr = sel_ptr - DMI_PTR_STEP;
        default: ind_addr = sel_ptr;
      endcase
    end
  end

  // Direct address is banked; the two port addresses redirect via pointer
  always_comb
  begin
    if (st_r.instr.file_addr == DMI_IND_PORT0_ADDR)
      store_addr = ptr_val[0];
    else if (st_r.instr.file_addr == DMI_IND_PORT1_ADDR)
      store_addr = ptr_val[1];
    else
      store_addr = {4'h0, st_r.bank, st_r.instr.file_addr};
  end

  // ----------------------------------------------------------------------
  // Sequencer: idle, decode, access, write; fixed length for every op
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.mem.rd = 1'b0;
    st_nxt.mem.wr = 1'b0;
    st_nxt.ptr_upd = 1'b0;
    case (st_r.state)
      DMI_ST_IDLE:
      begin
        if (instr_valid_in)
        begin
          st_nxt.instr = instr_in;
          st_nxt.state = DMI_ST_DECODE;
        end
      end
      DMI_ST_DECODE:
      begin
        st_nxt.state = DMI_ST_ACCESS;
        case (st_r.instr.op)
          DMI_OP_INDIRECT_LOAD_TO_ACC:
          begin
            st_nxt.mem.addr = ind_addr;
            st_nxt.mem.rd = 1'b1;
          end
          DMI_OP_LOAD_BANK_LITERAL: st_nxt.bank = st_r.instr.literal[4:0];
          DMI_OP_LOAD_PC_LATCH_LITERAL: st_nxt.pcl = st_r.instr.literal[6:0];
          DMI_OP_LOAD_ACC_LITERAL: st_nxt.acc = st_r.instr.literal;
          DMI_OP_STORE_ACC_TO_FILE:
          begin
            st_nxt.mem.addr = store_addr;
            st_nxt.mem.wdata = st_r.acc;
            st_nxt.mem.wr = 1'b1;
          end
          default: st_nxt.state = DMI_ST_ACCESS;
        endcase
      end
      DMI_ST_ACCESS:
      begin
        // Read data is valid here, in the same clock as the strobe
        st_nxt.state = DMI_ST_WRITE;
        if (is_ind)
        begin
          st_nxt.acc = mem_rdata_in;
          st_nxt.zero = (mem_rdata_in == 8'h00);
          st_nxt.ptr_upd = 1'b1;
        end
      end
      DMI_ST_WRITE: st_nxt.state = DMI_ST_IDLE;
      default: st_nxt.state = DMI_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      st_r.state <= DMI_ST_IDLE;
      st_r.instr <= '0;
      st_r.mem <= '0;
      st_r.acc <= DMI_ACC_RST;
      st_r.bank <= DMI_BANK_RST;
      st_r.pcl <= DMI_PCL_RST;
      st_r.zero <= DMI_ZERO_RST;
      st_r.ptr_upd <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign instr_ready_out = (st_r.state == DMI_ST_IDLE);
  assign done_out = (st_r.state == DMI_ST_WRITE);
  assign mem_req_out = st_r.mem;
  assign acc_out = st_r.acc;
  assign bank_select_reg_out = st_r.bank;
  assign pc_high_latch_out = st_r.pcl;
  assign zero_flag_out = st_r.zero;
  assign ptr0_out = ptr_val[0];
  assign ptr1_out = ptr_val[1];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  logic dec_ind;
  assign dec_ind = (st_r.state == DMI_ST_DECODE) && is_ind;

  AST_PRE_INC_ADDR: assert property (
    dec_ind && !st_r.instr.relative && st_r.instr.mode == DMI_MODE_PRE_INC
    |=> mem_req_out.rd && mem_req_out.addr == $past(sel_ptr) + DMI_PTR_STEP)
    else $error("pre-increment address wrong");

  AST_PRE_DEC_ADDR: assert property (
    dec_ind && !st_r.instr.relative && st_r.instr.mode == DMI_MODE_PRE_DEC
    |=> mem_req_out.rd && mem_req_out.addr == $past(sel_ptr) - DMI_PTR_STEP)
    else $error("pre-decrement address wrong");

  AST_POST_ADDR: assert property (
    dec_ind && !st_r.instr.relative && st_r.instr.mode[1]
    |=> mem_req_out.addr == $past(sel_ptr))
    else $error("post mode address is not the pointer");

  AST_REL_ADDR: assert property (
    dec_ind && st_r.instr.relative
    |=> mem_req_out.addr == $past(sel_ptr) + $past(offset_ext))
    else $error("relative address wrong");

  // Step lands at the write-to-idle edge; a load in the write clock loses to it
  AST_PTR_STEP: assert property (
    dec_ind && !st_r.instr.relative && !ptr_load_en_in ##1 !ptr_load_en_in ##1 1'b1
    |=> sel_ptr == ($past(sel_ptr, 3) + (st_r.instr.mode[0] ? 16'hFFFF : DMI_PTR_STEP)))
    else $error("pointer not stepped after indirect load");

  AST_PTR_REL_KEEP: assert property (
    dec_ind && st_r.instr.relative && !ptr_load_en_in ##1 !ptr_load_en_in ##1 !ptr_load_en_in
    |=> sel_ptr == $past(sel_ptr, 3))
    else $error("pointer moved in relative form");

  AST_BANK_LOAD: assert property (
    st_r.state == DMI_ST_DECODE && st_r.instr.op == DMI_OP_LOAD_BANK_LITERAL
    |=> bank_select_reg_out == $past(st_r.instr.literal[4:0]))
    else $error("bank select not loaded");

  AST_PCL_LOAD: assert property (
    st_r.state == DMI_ST_DECODE && st_r.instr.op == DMI_OP_LOAD_PC_LATCH_LITERAL
    |=> pc_high_latch_out == $past(st_r.instr.literal[6:0]))
    else $error("pc latch not loaded");

  AST_ACC_LOAD: assert property (
    st_r.state == DMI_ST_DECODE && st_r.instr.op == DMI_OP_LOAD_ACC_LITERAL
    |=> acc_out == $past(st_r.instr.literal))
    else $error("accumulator not loaded");

  AST_STORE: assert property (
    st_r.state == DMI_ST_DECODE && st_r.instr.op == DMI_OP_STORE_ACC_TO_FILE
    |=> mem_req_out.wr && mem_req_out.wdata == acc_out ##0 $stable(acc_out) [*3])
    else $error("store wrong or accumulator changed");

  AST_ZERO_FLAG: assert property (
    st_r.state == DMI_ST_ACCESS && is_ind |=> zero_flag_out == (acc_out == 8'h00))
    else $error("zero flag does not follow loaded value");

  AST_FLAGS_KEEP: assert property (
    st_r.state == DMI_ST_DECODE && !is_ind |=> $stable(zero_flag_out) [*3])
    else $error("flag changed by non-indirect move");

  AST_ONE_CYCLE: assert property (
    instr_valid_in && instr_ready_out |=> !done_out ##1 !done_out ##1 done_out)
    else $error("instruction length wrong");

endmodule : dmi_exec

`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the data-move executor: corner cases, then seeded random words.
// Assumes the memory answers in the same cycle as the read strobe, and a fixed 4-cycle slot.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import dmi_pkg::*;
  logic ref_clk_in, reset_n_in, instr_valid_in, ptr_load_en_in, ptr_load_sel_in;
  dmi_instr_type instr_in;
  logic [15:0] ptr_load_val_in, ptr0_out, ptr1_out;
  logic [7:0] mem_rdata_in, junk_r, acc_out, acc_m;
  logic instr_ready_out, done_out, zero_flag_out, z_m;
  dmi_mem_req_type mem_req_out;
  logic [4:0] bank_select_reg_out, bank_m;
  logic [6:0] pc_high_latch_out, pcl_m;
  logic [15:0] ptr_m [2];
  int fail_count, n_checks, cycles, seed, k;
  logic [31:0] r;

  dmi_exec u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out), .done_out(done_out),
    .ptr_load_en_in(ptr_load_en_in), .ptr_load_sel_in(ptr_load_sel_in),
    .ptr_load_val_in(ptr_load_val_in), .mem_req_out(mem_req_out),
    .mem_rdata_in(mem_rdata_in), .acc_out(acc_out), .bank_select_reg_out(bank_select_reg_out),
    .pc_high_latch_out(pc_high_latch_out), .zero_flag_out(zero_flag_out),
    .ptr0_out(ptr0_out), .ptr1_out(ptr1_out));

  // ----------------------------------------------------------------
  // Clock, memory stand-in, timeout
  // ----------------------------------------------------------------
  always #2 ref_clk_in = ~ref_clk_in;
  // Junk outside a read so a stale byte can never look right
  assign mem_rdata_in = mem_req_out.rd ? rd_fn(mem_req_out.addr) : junk_r;
  always @(posedge ref_clk_in)
  begin
    junk_r <= ~junk_r + 8'h35;
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      $display("BAD t=%0t run hung", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte stored at an address; zero wherever the two bytes xor to 3Ch
  function automatic logic [7:0] rd_fn(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3c;
  endfunction : rd_fn

  function automatic dmi_instr_type mk(input logic [2:0] op, input logic s, input logic [1:0] m,
      input logic rl, input logic [5:0] o, input logic [7:0] l, input logic [6:0] f);
    return {op, s, m, rl, o, l, f};
  endfunction : mk

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Pointer load, entered and left at a falling edge
  task automatic pload(input logic s, input logic [15:0] v);
    ptr_load_en_in = 1'b1;
    ptr_load_sel_in = s;
    ptr_load_val_in = v;
    @(negedge ref_clk_in);
    ptr_load_en_in = 1'b0;
    ptr_m[s] = v;
  endtask : pload

  // One instruction slot; poke offers a second word while busy
  task automatic run(input dmi_instr_type i, input logic poke);
    logic [15:0] p, ea, np, wa;
    logic ind, st;
    p = ptr_m[i.ptr_sel];
    ind = (i.op == DMI_OP_INDIRECT_LOAD_TO_ACC);
    st = (i.op == DMI_OP_STORE_ACC_TO_FILE);
    ea = i.relative ? p + {{10{i.offset[5]}}, i.offset} :
      (i.mode == DMI_MODE_PRE_INC ? p + 16'h0001 : (i.mode == DMI_MODE_PRE_DEC ? p - 16'h0001 : p));
    np = (i.relative || !ind) ? p : (i.mode[0] ? p - 16'h0001 : p + 16'h0001);
    wa = (i.file_addr == 7'h00) ? ptr_m[0] :
      ((i.file_addr == 7'h01) ? ptr_m[1] : {4'h0, bank_m, i.file_addr});
    case (i.op)
      DMI_OP_INDIRECT_LOAD_TO_ACC: {acc_m, z_m} = {rd_fn(ea), rd_fn(ea) == 8'h00};
      DMI_OP_LOAD_BANK_LITERAL: bank_m = i.literal[4:0];
      DMI_OP_LOAD_PC_LATCH_LITERAL: pcl_m = i.literal[6:0];
      DMI_OP_LOAD_ACC_LITERAL: acc_m = i.literal;
      default: ;
    endcase
    ptr_m[i.ptr_sel] = np;
    chk({15'h0, instr_ready_out}, 16'h0001, "ready idle");
    instr_in = i;
    instr_valid_in = 1'b1;
    @(negedge ref_clk_in);
    instr_valid_in = poke;
    instr_in = mk(3'h4, 1'b0, 2'h0, 1'b0, 6'h00, ~acc_m, 7'h00);
    chk({15'h0, instr_ready_out}, 16'h0000, "busy");
    @(negedge ref_clk_in);
    chk({14'h0, mem_req_out.rd, mem_req_out.wr}, {14'h0, ind, st}, "strobes");
    if (ind)
      chk(mem_req_out.addr, ea, "read addr");
    if (st)
    begin
      chk(mem_req_out.addr, wa, "store addr");
      chk({8'h0, mem_req_out.wdata}, {8'h0, acc_m}, "store data");
    end
    @(negedge ref_clk_in);
    instr_valid_in = 1'b0;
    chk({15'h0, done_out}, 16'h0001, "done");
    @(negedge ref_clk_in);
    chk({15'h0, done_out, instr_ready_out}, 16'h0001, "slot end");
    chk({8'h0, acc_out}, {8'h0, acc_m}, "acc");
    chk({15'h0, zero_flag_out}, {15'h0, z_m}, "zero");
    chk({4'h0, bank_select_reg_out, pc_high_latch_out}, {4'h0, bank_m, pcl_m}, "lits");
    chk(ptr0_out, ptr_m[0], "ptr0");
    chk(ptr1_out, ptr_m[1], "ptr1");
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {ref_clk_in, reset_n_in, instr_valid_in, ptr_load_en_in, ptr_load_sel_in} = 5'h00;
    {instr_in, ptr_load_val_in, junk_r} = '0;
    {acc_m, bank_m, pcl_m, z_m, ptr_m[0], ptr_m[1]} = '0;
    {fail_count, n_checks, cycles} = '0;
    seed = 34046;
    repeat (2) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    // Every mode on both pointers at both wrap ends
    for (k = 0; k < 16; k++)
    begin
      pload(k[0], k[1] ? 16'hffff : 16'h0000);
      run(mk(3'h1, k[0], k[3:2], 1'b0, 6'h00, 8'h00, 7'h00), 1'b0);
    end
    $display("test wrap done");
    pload(1'b0, 16'h3c00);
    run(mk(3'h1, 1'b0, 2'h2, 1'b0, 6'h00, 8'h00, 7'h00), 1'b0);
    run(mk(3'h1, 1'b1, 2'h0, 1'b1, 6'h20, 8'h00, 7'h00), 1'b1);
    run(mk(3'h1, 1'b0, 2'h3, 1'b1, 6'h1f, 8'h00, 7'h00), 1'b0);
    $display("test offset done");
    run(mk(3'h2, 1'b0, 2'h0, 1'b0, 6'h00, 8'hff, 7'h00), 1'b0);
    run(mk(3'h3, 1'b0, 2'h0, 1'b0, 6'h00, 8'hff, 7'h00), 1'b1);
    run(mk(3'h4, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00, 7'h00), 1'b0);
    run(mk(3'h4, 1'b0, 2'h0, 1'b0, 6'h00, 8'hff, 7'h00), 1'b0);
    for (k = 0; k < 3; k++)
      run(mk(3'h5, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00, k == 2 ? 7'h7f : k[6:0]), 1'b0);
    run(mk(3'h0, 1'b0, 2'h0, 1'b0, 6'h00, 8'h00, 7'h00), 1'b0);
    $display("test literal and store done");
    // Seeded random words, pointers reloaded now and then
    for (k = 0; k < 60; k++)
    begin
      r = $random(seed);
      if (r[31:30] == 2'b00)
        pload(r[29], r[15:0]);
      r = $random(seed);
      run(mk(r[2:0] > 3'h5 ? 3'h0 : r[2:0], r[3], r[5:4], r[6], r[12:7], r[20:13], r[27:21]),
        r[28]);
    end
    $display("test random done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire
